//--- dcod_defs.svh
// constants shared by both ends of the current-output link
`ifndef DCOD_DEFS_SVH
`define DCOD_DEFS_SVH

`define DCOD_CLK_MHZ      200
`define DCOD_WD_MS        100
`define DCOD_WD_CYCLES    (`DCOD_WD_MS * 1000 * `DCOD_CLK_MHZ)

`define DCOD_IDX_MOFF     6'd19
`define DCOD_IDX_MGAIN    6'd20
`define DCOD_IDX_CODE     6'd31
`define DCOD_IDX_FEAT     6'd32
`define DCOD_IDX_UOFF     6'd33
`define DCOD_IDX_UGAIN    6'd34
`define DCOD_IDX_SUBST    6'd35
`define DCOD_IDX_PAR_LO   6'd16
`define DCOD_IDX_PAR_HI   6'd47

`define DCOD_UNLOCK       16'h1235
`define DCOD_GAIN_ONE     16'h0100
`define DCOD_GAIN_SHIFT   8
`define DCOD_ZERO16       16'h0000
`define DCOD_FEAT_RST     16'h0000
`define DCOD_FEAT_USER    0
`define DCOD_FEAT_MFR     1

`define DCOD_CB_REG       7
`define DCOD_CB_WNR       6
`define DCOD_CB_ADDR_MSB  5
`define DCOD_STAT_IDLE    8'h00

`define DCOD_DAC_MSB      14
`define DCOD_DAC_LSB      3
`define DCOD_DAC_ZERO     12'h000
`define DCOD_MAX16        16'h7fff
`define DCOD_MIN16        16'h8000
`define DCOD_SAT_MAX      33'sh0_0000_7fff
`define DCOD_SAT_MIN      33'sh1_ffff_8000

`define DCOD_A_CTRL       8'h00
`define DCOD_A_CH0        8'h04
`define DCOD_A_CH1        8'h08
`define DCOD_A_IRQST      8'h0c
`define DCOD_A_IRQMSK     8'h10
`define DCOD_CTRL_GO      8
`define DCOD_CH_DATA_LSB  8
`define DCOD_CH_DATA_MSB  23

`endif

//--- dcod_pkg.sv
// state types for both ends of the current-output link
package dcod_pkg;

    typedef struct packed {
        logic [1:0][15:0] code;
        logic [1:0][15:0] feat;
        logic [1:0][15:0] mOff;
        logic [1:0][15:0] mGain;
        logic [1:0][15:0] uOff;
        logic [1:0][15:0] uGain;
        logic [1:0][15:0] subst;
        logic [1:0][15:0] proc;
        logic [1:0][15:0] rdData;
        logic [1:0][7:0]  stat;
        logic [1:0][24:0] wdCnt;
        logic [1:0]       alive;
        logic [1:0][11:0] dac;
    } dcod_term_type;

    typedef struct packed {
        logic [1:0]       mapCtl;
        logic [1:0][15:0] outWord;
        logic [1:0][7:0]  ctl;
        logic             xfer;
        logic             pend;
        logic [1:0]       irqSt;
        logic [1:0]       irqMsk;
        logic             irq;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } dcod_cpl_type;

endpackage : dcod_pkg

//--- dcod_link_if.sv
// process image link between coupler and two-channel output terminal
`timescale 1ns/1ps
interface dcod_link_if;
    logic             xfer;
    logic [1:0][15:0] outWord;
    logic [1:0][7:0]  ctlByte;
    logic [1:0][15:0] inWord;
    logic [1:0][7:0]  statByte;

    modport term (
        input  xfer,
        input  outWord,
        input  ctlByte,
        output inWord,
        output statByte
    );

    modport coupler (
        output xfer,
        output outWord,
        output ctlByte,
        input  inWord,
        input  statByte
    );
endinterface : dcod_link_if

//--- dcod_terminal.sv
// terminal end: per-channel scaling, watchdog and register set
// Operation
// - process word is signed twos complement
// - converter code has twelve bits
// - alive indicator drops after 100 ms silence
// - expired watchdog drives user substitute value
// - no scaling passes word unchanged
// - single stage: offset plus gain times word
// - both stages: manufacturer first, then user
// - feature register bits enable scaling stages
// - 16-bit word plus optional control/status byte
// - unmapped control: four output data bytes
// - register access needs mapped control byte
// - control byte sits in low byte
// - control bit7 register mode, bit6 write
// - unlock code guards parameter writes
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "dcod_defs.svh"
module dcod_terminal
    import dcod_pkg::*;
#(
    parameter int unsigned WD_CYCLES = `DCOD_WD_CYCLES
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    dcod_link_if.term             link,
    output logic      [1:0][11:0] dacCode,
    output logic      [1:0]       channelAlive
);

    localparam logic [24:0] WD_LAST = 25'(WD_CYCLES - 1);

    dcod_term_type s_q;
    dcod_term_type s_d;

    logic [1:0][15:0] mfrOut;
    logic [1:0][15:0] usrIn;
    logic [1:0][15:0] usrOut;
    logic [1:0][15:0] scaled;
    logic [1:0][11:0] procCode;
    logic [1:0][11:0] substCode;

    // user stage takes the manufacturer result only when that stage is on
    for (genvar g = 0; g < 2; g++) begin : g_chan
        assign usrIn[g] = s_q.feat[g][`DCOD_FEAT_MFR] ? mfrOut[g]
                                                      : s_q.proc[g];
        assign scaled[g] = s_q.feat[g][`DCOD_FEAT_USER] ? usrOut[g]
                                                        : usrIn[g];
        dcod_lin_stage u_mfr_stage (
            .x    (s_q.proc[g]),
            .off  (s_q.mOff[g]),
            .gain (s_q.mGain[g]),
            .y    (mfrOut[g])
        );
        dcod_lin_stage u_usr_stage (
            .x    (usrIn[g]),
            .off  (s_q.uOff[g]),
            .gain (s_q.uGain[g]),
            .y    (usrOut[g])
        );
        dcod_dac_map u_proc_map (
            .word (scaled[g]),
            .code (procCode[g])
        );
        // substitute is a process-scale word and skips both stages
        dcod_dac_map u_subst_map (
            .word (s_q.subst[g]),
            .code (substCode[g])
        );
    end

    function automatic logic is_param(input logic [5:0] idx);
        is_param = (idx >= `DCOD_IDX_PAR_LO) && (idx <= `DCOD_IDX_PAR_HI);
    endfunction : is_param

    always_comb begin
        logic [15:0] w;
        logic [5:0]  idx;
        logic        unlocked;
        logic [7:0]  cb;
        w = `DCOD_ZERO16;
        idx = '0;
        unlocked = 1'b0;
        cb = '0;
        s_d = s_q;
        for (int i = 0; i < 2; i++) begin
            cb = link.ctlByte[i];
            w = link.outWord[i];
            idx = cb[`DCOD_CB_ADDR_MSB:0];
            unlocked = (s_q.code[i] == `DCOD_UNLOCK);
            // watchdog counts silence only; any transfer rearms it
            if (link.xfer) begin
                s_d.wdCnt[i] = '0;
                s_d.alive[i] = 1'b1;
            end else if (s_q.wdCnt[i] == WD_LAST) begin
                s_d.alive[i] = 1'b0;
            end else begin
                s_d.wdCnt[i] = s_q.wdCnt[i] + 25'd1;
            end
            if (link.xfer && cb[`DCOD_CB_REG]) begin
                // register mode: data word carries register traffic
                if (cb[`DCOD_CB_WNR]) begin
                    if (idx == `DCOD_IDX_CODE) begin
                        s_d.code[i] = w;
                    end else if (unlocked && is_param(idx)) begin
                        case (idx)
                            `DCOD_IDX_MOFF: s_d.mOff[i] = w;
                            `DCOD_IDX_MGAIN: s_d.mGain[i] = w;
                            `DCOD_IDX_FEAT: s_d.feat[i] = w;
                            `DCOD_IDX_UOFF: s_d.uOff[i] = w;
                            `DCOD_IDX_UGAIN: s_d.uGain[i] = w;
                            `DCOD_IDX_SUBST: s_d.subst[i] = w;
                            default: s_d.subst[i] = s_q.subst[i];
                        endcase
                    end
                end
                case (idx)
                    `DCOD_IDX_CODE: begin
                        s_d.rdData[i] = unlocked ? s_q.code[i]
                                                 : `DCOD_ZERO16;
                    end
                    `DCOD_IDX_MOFF: s_d.rdData[i] = s_q.mOff[i];
                    `DCOD_IDX_MGAIN: s_d.rdData[i] = s_q.mGain[i];
                    `DCOD_IDX_FEAT: s_d.rdData[i] = s_q.feat[i];
                    `DCOD_IDX_UOFF: s_d.rdData[i] = s_q.uOff[i];
                    `DCOD_IDX_UGAIN: s_d.rdData[i] = s_q.uGain[i];
                    `DCOD_IDX_SUBST: s_d.rdData[i] = s_q.subst[i];
                    default: s_d.rdData[i] = `DCOD_ZERO16;
                endcase
                // echo marks completion to the coupler
                s_d.stat[i] = cb;
            end else if (link.xfer) begin
                s_d.proc[i] = w;
                s_d.stat[i] = `DCOD_STAT_IDLE;
            end
            // selection follows the registered indicator, so a transfer
            // after expiry never shows the stale word for one cycle
            if (s_q.alive[i]) begin
                s_d.dac[i] = procCode[i];
            end else begin
                s_d.dac[i] = substCode[i];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q.code <= '0;
            s_q.feat <= {2{`DCOD_FEAT_RST}};
            s_q.mOff <= {2{`DCOD_ZERO16}};
            s_q.mGain <= {2{`DCOD_GAIN_ONE}};
            s_q.uOff <= {2{`DCOD_ZERO16}};
            s_q.uGain <= {2{`DCOD_GAIN_ONE}};
            s_q.subst <= {2{`DCOD_ZERO16}};
            s_q.proc <= {2{`DCOD_ZERO16}};
            s_q.rdData <= {2{`DCOD_ZERO16}};
            s_q.stat <= {2{`DCOD_STAT_IDLE}};
            s_q.wdCnt <= '0;
            s_q.alive <= '0;
            s_q.dac <= {2{`DCOD_DAC_ZERO}};
        end else begin
            s_q <= s_d;
        end
    end

    assign dacCode = s_q.dac;
    assign channelAlive = s_q.alive;
    assign link.inWord = s_q.rdData;
    assign link.statByte = s_q.stat;

endmodule : dcod_terminal

// one straight-line stage: offset plus gain times word, saturated
module dcod_lin_stage
    import dcod_pkg::*;
#(
    parameter int unsigned FRAC = `DCOD_GAIN_SHIFT
) (
    input  wire logic [15:0] x,
    input  wire logic [15:0] off,
    input  wire logic [15:0] gain,
    output logic      [15:0] y
);

    logic signed [31:0] prod;
    logic signed [32:0] sum;

    // gain is signed with FRAC fraction bits, offset a signed word;
    // clamping keeps an overflow from folding to the opposite rail
    always_comb begin
        prod = $signed(gain) * $signed(x);
        sum = 33'(prod >>> FRAC) + 33'($signed(off));
        if (sum > `DCOD_SAT_MAX) begin
            y = `DCOD_MAX16;
        end else if (sum < `DCOD_SAT_MIN) begin
            y = `DCOD_MIN16;
        end else begin
            y = sum[15:0];
        end
    end

endmodule : dcod_lin_stage

// converter code from a signed word: negative clamps to zero current
module dcod_dac_map
    import dcod_pkg::*;
#(
    parameter int unsigned MSB = `DCOD_DAC_MSB,
    parameter int unsigned LSB = `DCOD_DAC_LSB
) (
    input  wire logic [15:0] word,
    output logic      [11:0] code
);

    always_comb begin
        if (word[15]) begin
            code = `DCOD_DAC_ZERO;
        end else begin
            code = word[MSB:LSB];
        end
    end

endmodule : dcod_dac_map

//--- dcod_coupler.sv
// coupler end: apb register file driving the process image link
`timescale 1ns/1ps
`include "dcod_defs.svh"
module dcod_coupler
    import dcod_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    dcod_link_if.coupler     link
);

    dcod_cpl_type s_q;
    dcod_cpl_type s_d;

    always_comb begin
        logic setup;
        logic wr;
        logic hit;
        logic [1:0] done;
        setup = psel && !penable;
        wr = psel && penable && pwrite && s_q.pready && !s_q.pslverr;
        hit = 1'b1;
        done = '0;
        s_d = s_q;
        s_d.xfer = 1'b0;
        s_d.pend = s_q.xfer;
        // answer in the first access cycle
        s_d.pready = setup;
        s_d.pslverr = 1'b0;
        if (setup) begin
            case (paddr)
                `DCOD_A_CTRL: s_d.prdata = {30'h0, s_q.mapCtl};
                `DCOD_A_CH0: s_d.prdata = {8'h00, link.inWord[0],
                                           link.statByte[0]};
                `DCOD_A_CH1: s_d.prdata = {8'h00, link.inWord[1],
                                           link.statByte[1]};
                `DCOD_A_IRQST: s_d.prdata = {30'h0, s_q.irqSt};
                `DCOD_A_IRQMSK: s_d.prdata = {30'h0, s_q.irqMsk};
                default: begin
                    s_d.prdata = '0;
                    hit = 1'b0;
                end
            endcase
            s_d.pslverr = !hit;
        end
        if (wr) begin
            case (paddr)
                `DCOD_A_CTRL: begin
                    s_d.mapCtl = pwdata[1:0];
                    s_d.xfer = pwdata[`DCOD_CTRL_GO];
                end
                `DCOD_A_CH0: begin
                    s_d.ctl[0] = pwdata[7:0];
                    s_d.outWord[0] = pwdata[`DCOD_CH_DATA_MSB:
                                            `DCOD_CH_DATA_LSB];
                end
                `DCOD_A_CH1: begin
                    s_d.ctl[1] = pwdata[7:0];
                    s_d.outWord[1] = pwdata[`DCOD_CH_DATA_MSB:
                                            `DCOD_CH_DATA_LSB];
                end
                `DCOD_A_IRQMSK: s_d.irqMsk = pwdata[1:0];
                `DCOD_A_IRQST: s_d.irqSt = s_q.irqSt & ~pwdata[1:0];
                default: s_d.irqMsk = s_q.irqMsk;
            endcase
        end
        // register access completes when status echoes control
        for (int i = 0; i < 2; i++) begin
            done[i] = s_q.pend && s_q.mapCtl[i]
                      && s_q.ctl[i][`DCOD_CB_REG]
                      && (link.statByte[i] == s_q.ctl[i]);
        end
        // set wins over a write-one clear in the same cycle
        s_d.irqSt = s_d.irqSt | done;
        s_d.irq = |(s_d.irqSt & s_d.irqMsk);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq = s_q.irq;
    assign link.xfer = s_q.xfer;
    assign link.outWord = s_q.outWord;
    // unmapped channel sends only its two data bytes, never register mode
    assign link.ctlByte[0] = s_q.mapCtl[0] ? s_q.ctl[0] : 8'h00;
    assign link.ctlByte[1] = s_q.mapCtl[1] ? s_q.ctl[1] : 8'h00;

endmodule : dcod_coupler

//--- dcod_link_asserts.sv
// concurrent checks on the coupler-terminal link and terminal outputs
`timescale 1ns/1ps
`include "dcod_defs.svh"
module dcod_link_asserts
    import dcod_pkg::*;
#(
    parameter int unsigned WD_CYCLES = `DCOD_WD_CYCLES
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             xfer,
    input  wire logic [1:0][7:0]  ctlByte,
    input  wire logic [1:0][15:0] inWord,
    input  wire logic [1:0][7:0]  statByte,
    input  wire logic [1:0][11:0] dacCode,
    input  wire logic [1:0]       channelAlive
);
    int unsigned quietCnt_q;

    // saturates past the timeout so a long idle span never wraps
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            quietCnt_q <= WD_CYCLES + 3;
        end else if (xfer) begin
            quietCnt_q <= 0;
        end else if (quietCnt_q < WD_CYCLES + 3) begin
            quietCnt_q <= quietCnt_q + 1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_alive_on_xfer: assert property (xfer |=> channelAlive == 2'b11)
        else $error("alive not raised after transfer");
    a_alive_drop: assert property (
        quietCnt_q >= WD_CYCLES + 2 |-> channelAlive == 2'b00)
        else $error("alive still high after timeout");
    a_alive_held: assert property (
        quietCnt_q + 2 < WD_CYCLES |-> channelAlive == 2'b11)
        else $error("alive dropped before timeout");
    a_echo_ch0: assert property (
        xfer && ctlByte[0][7] |=> statByte[0] == $past(ctlByte[0]))
        else $error("channel 0 status does not echo control");
    a_echo_ch1: assert property (
        xfer && ctlByte[1][7] |=> statByte[1] == $past(ctlByte[1]))
        else $error("channel 1 status does not echo control");
    a_proc_status: assert property (
        xfer && !ctlByte[0][7] |=> statByte[0] == 8'h00)
        else $error("process mode status not zero");
    a_link_hold: assert property (
        !xfer |=> $stable(inWord) && $stable(statByte))
        else $error("terminal answer changed without transfer");
    a_xfer_pulse: assert property (xfer |=> !xfer)
        else $error("transfer strobe longer than one cycle");
    a_dac_timing: assert property (
        $changed(dacCode) |-> quietCnt_q == 1 || quietCnt_q + 3 >= WD_CYCLES)
        else $error("converter code changed at wrong time");
endmodule : dcod_link_asserts

//--- dcod_tb_top.sv
// self-checking bench: apb coupler driving the two-channel terminal
`timescale 1ns/1ps
`include "dcod_defs.svh"
module dcod_tb_top;
    localparam int WD = 50;
    logic             clock = 1'b0;
    logic             nrst;
    logic [7:0]       paddr;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
    logic             slvErr;
    logic [31:0]      rd;
    logic [1:0][11:0] dacCode;
    logic [1:0]       channelAlive;
    int               err_count = 0;
    int               checked = 0;
    logic [15:0]      pIn [4] = '{16'h7fff, 16'h3fff, 16'hffff, 16'h0008};
    logic [11:0]      pExp [4] = '{12'hfff, 12'h7ff, 12'h000, 12'h001};

    always #2.5 clock = ~clock;

    dcod_link_if linkBus ();
    dcod_coupler u_dcod_coupler (.clock(clock), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(linkBus));
    dcod_terminal #(.WD_CYCLES(WD)) u_dcod_terminal (.clock(clock),
        .nrst(nrst), .link(linkBus), .dacCode(dacCode),
        .channelAlive(channelAlive));
    dcod_link_asserts #(.WD_CYCLES(WD)) u_dcod_link_asserts (.clock(clock),
        .nrst(nrst), .xfer(linkBus.xfer), .ctlByte(linkBus.ctlByte),
        .inWord(linkBus.inWord), .statByte(linkBus.statByte),
        .dacCode(dacCode), .channelAlive(channelAlive));

    task automatic results();
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // entered just after an edge; leaves one idle cycle so no strobe
    // is assigned twice in one time step
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // waits as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic send(input logic [7:0] ctl, input logic [15:0] d,
                        input logic [1:0] map);
        apb(`DCOD_A_CH0, 1'b1, {8'h00, d, ctl});
        apb(`DCOD_A_CH1, 1'b1, {8'h00, d, ctl});
        apb(`DCOD_A_CTRL, 1'b1, {23'h0, 1'b1, 6'h0, map});
        repeat (6) @(posedge clock);
    endtask : send

    task automatic wrReg(input logic [5:0] idx, input logic [15:0] v);
        send({2'b11, idx}, v, 2'b11);
    endtask : wrReg

    task automatic rdReg(input logic [5:0] idx, input logic [15:0] v);
        send({2'b10, idx}, 16'h0000, 2'b11);
        apb(`DCOD_A_CH0, 1'b0, 32'h0);
        chk({16'h0, rd[23:8]}, {16'h0, v});
        chk({24'h0, rd[7:0]}, {24'h0, 2'b10, idx});
    endtask : rdReg

    task automatic proc(input logic [15:0] x, input logic [11:0] e);
        send(8'h00, x, 2'b11);
        chk({20'h0, dacCode[0]}, {20'h0, e});
        chk({20'h0, dacCode[1]}, {20'h0, e});
    endtask : proc

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk({6'h0, dacCode, channelAlive}, 32'h0);
        apb(`DCOD_A_IRQMSK, 1'b1, 32'h3);
        for (int i = 0; i < 4; i++) proc(pIn[i], pExp[i]);
        wrReg(6'd32, 16'h0003);
        rdReg(6'd32, 16'h0000);
        rdReg(6'd31, 16'h0000);
        chk({31'h0, irq}, 32'h1);
        apb(`DCOD_A_IRQST, 1'b0, 32'h0);
        chk(rd, 32'h3);
        apb(`DCOD_A_IRQST, 1'b1, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wrReg(6'd31, 16'h1235);
        rdReg(6'd31, 16'h1235);
        send(8'he0, 16'h0003, 2'b00);
        rdReg(6'd32, 16'h0000);
        apb(8'h14, 1'b0, 32'h0);
        chk({31'h0, slvErr}, 32'h1);
        wrReg(6'd33, 16'h0100);
        wrReg(6'd34, 16'h0200);
        wrReg(6'd32, 16'h0001);
        proc(16'h1000, 12'h420);
        wrReg(6'd19, 16'h0010);
        wrReg(6'd20, 16'h0080);
        wrReg(6'd32, 16'h0003);
        proc(16'h1000, 12'h224);
        proc(16'h7fff, 12'hfff);
        wrReg(6'd35, 16'h3fff);
        repeat (WD + 10) @(posedge clock);
        chk({30'h0, channelAlive}, 32'h0);
        chk({8'h0, dacCode}, {8'h0, 12'h7ff, 12'h7ff});
        proc(16'h0000, 12'h024);
        chk({30'h0, channelAlive}, 32'h3);
        wrReg(6'd31, 16'h0000);
        wrReg(6'd32, 16'h0000);
        rdReg(6'd32, 16'h0003);
        results();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        results();
    end
endmodule : dcod_tb_top
